//--- core/offset_scratch_id_regs.sv
// Purpose: Two-wire slave with offset, scratch, limit and identity registers
// Assumes: Samples from converter logic share the core clock
// Notes: Bus pins and the address select pin pass a three-stage filter
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - add offset to every linearised result
// - offset two's complement, same scale as result
// - clamp out-of-range sum to max or min
// - offset word at 07h, resets to zero
// - scratch word at 06h, read/write, no meaning
// - scratch words backed by nonvolatile location
// - scratch word at 08h, reset from stored value
// - identity word at 0Fh is read-only
// - identity: revision 15:12, part code 11:0
// - slave only, clock in, data bidirectional
// - four bus addresses from select pin wiring
// - alert when result crosses limits 02h/03h
// - average over 1, 8, 32 or 64 conversions
// - unlock set makes scratch writes program storage
// - general-call reset, 1.5 ms wait, then sample
module offset_scratch_id_regs import tsense_pkg::*; #(
  parameter int GC_RESET_CYCLES_P = GC_RESET_CYCLES,
  parameter logic [3:0] REV_FIELD = 4'h3, // Arbitrary value
  parameter logic [11:0] PART_CODE_FIELD = 12'hA5C // Arbitrary value
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // Two-wire bus
  input wire logic I_SCL,
  input wire logic I_SDA,
  output var logic O_SDA_O,
  output var logic O_SDA_OE,
  input wire logic I_ADDRESS_SELECT_PIN,
  // Converter side
  input wire logic [15:0] I_SAMPLE,
  input wire logic I_SAMPLE_VALID,
  input wire logic [1:0] I_AVG_SEL,
  output var logic O_SAMPLING,
  output var logic O_ALERT,
  // Nonvolatile store
  input wire logic [47:0] I_NVM_STORED,
  output var logic O_NVM_WR,
  output var logic [1:0] O_NVM_SEL,
  output var logic [15:0] O_NVM_DATA
);
  localparam int WAIT_W = $clog2(GC_RESET_CYCLES_P + 1);
  localparam logic [15:0] ID_WORD = {REV_FIELD, PART_CODE_FIELD};

  logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_q_r;
  logic scl_rise, scl_fall, start, stop;
  bus_state_type state_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r, ptr_r, hi_r;
  logic rw_r, gc_r, rd_lo_r, nack_r, sel0_r, self_r, selr_r;
  logic [1:0] bidx_r;
  logic [6:0] my_addr;
  logic [15:0] rd_word, wdata_r;
  logic [7:0] rd_byte;
  logic wr_stb_r, gc_hit_r, boot_r, unlock_r;
  logic [15:0] high_r, low_r, offset_r, result;
  logic [15:0] scr_r [SCR_NUM];
  logic [SCR_NUM-1:0] scr_hit;
  logic res_valid;
  logic [WAIT_W-1:0] wait_r;

  // Pin filter: bits are {select, data, clock}
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_s1_r <= 3'h3;
      pin_s2_r <= 3'h3;
      pin_s3_r <= 3'h3;
      pin_f_r <= 3'h3;
      pin_q_r <= 3'h3;
    end else begin
      pin_s1_r <= {I_ADDRESS_SELECT_PIN, I_SDA, I_SCL};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_s2_r & pin_s3_r) | ((pin_s2_r ^ pin_s3_r) & pin_f_r);
      pin_q_r <= pin_f_r;
    end
  end

  always_comb begin
    scl_rise = pin_f_r[0] && !pin_q_r[0];
    scl_fall = !pin_f_r[0] && pin_q_r[0];
    start = pin_f_r[0] && pin_q_r[0] && pin_q_r[1] && !pin_f_r[1];
    stop = pin_f_r[0] && pin_q_r[0] && !pin_q_r[1] && pin_f_r[1];
    // Pin wiring seen at start, first low and first high of the clock
    my_addr = {BUS_ADDR_BASE, sel0_r ? (self_r ? SEL_VCC : SEL_SCL)
                                     : (selr_r ? SEL_SDA : SEL_GND)};
    case (ptr_r)
      IDX_RESULT: rd_word = result;
      IDX_HIGH: rd_word = high_r;
      IDX_LOW: rd_word = low_r;
      IDX_UNLOCK: rd_word = {unlock_r, 15'h0000};
      IDX_SCR_A: rd_word = scr_r[0];
      IDX_SCR_B: rd_word = scr_r[1];
      IDX_OFFSET: rd_word = offset_r;
      IDX_SCR_C: rd_word = scr_r[2];
      IDX_ID: rd_word = ID_WORD;
      default: rd_word = 16'h0000;
    endcase
    rd_byte = rd_lo_r ? rd_word[7:0] : rd_word[15:8];
  end

  // Bus slave: never drives the clock, only pulls data low
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'hFF;
      ptr_r <= 8'h00;
      hi_r <= 8'h00;
      wdata_r <= 16'h0000;
      bidx_r <= 2'h0;
      {rw_r, gc_r, rd_lo_r, nack_r, sel0_r, self_r, selr_r} <= 7'h00;
      O_SDA_O <= 1'b0;
      O_SDA_OE <= 1'b0;
      wr_stb_r <= 1'b0;
      gc_hit_r <= 1'b0;
    end else begin
      O_SDA_O <= 1'b0;
      wr_stb_r <= 1'b0;
      gc_hit_r <= 1'b0;
      if (stop) begin
        state_r <= ST_IDLE;
        O_SDA_OE <= 1'b0;
      end else if (start) begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        O_SDA_OE <= 1'b0;
        sel0_r <= pin_f_r[2];
      end else begin
        unique case (state_r)
          ST_IDLE: ;
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], pin_f_r[1]};
              cnt_r <= cnt_r + 4'h1;
              if (state_r == ST_ADDR && cnt_r == 4'h0) selr_r <= pin_f_r[2];
            end
            if (scl_fall && state_r == ST_ADDR && cnt_r == 4'h0) self_r <= pin_f_r[2];
            if (scl_fall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (sh_r[7:1] == my_addr || sh_r == 8'h00) begin
                  O_SDA_OE <= 1'b1;
                  state_r <= ST_ACK;
                  rw_r <= sh_r[0];
                  gc_r <= (sh_r == 8'h00);
                  bidx_r <= 2'h0;
                  rd_lo_r <= 1'b0;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                O_SDA_OE <= 1'b1;
                state_r <= ST_ACK;
                if (gc_r) begin
                  gc_hit_r <= (sh_r == GC_RESET_CMD);
                end else if (bidx_r == 2'h0) begin
                  ptr_r <= sh_r;
                  bidx_r <= 2'h1;
                end else if (bidx_r == 2'h1) begin
                  hi_r <= sh_r;
                  bidx_r <= 2'h2;
                end else begin
                  wr_stb_r <= 1'b1;
                  wdata_r <= {hi_r, sh_r};
                  bidx_r <= 2'h1;
                end
              end
            end
          end
          ST_ACK, ST_MACK: begin
            if (scl_rise && state_r == ST_MACK) nack_r <= pin_f_r[1];
            if (scl_fall) begin
              cnt_r <= 4'h0;
              if (!rw_r) begin
                O_SDA_OE <= 1'b0;
                state_r <= ST_WR;
              end else if (state_r == ST_MACK && nack_r) begin
                state_r <= ST_IDLE;
              end else begin
                O_SDA_OE <= !rd_byte[7];
                tx_r <= {rd_byte[6:0], 1'b1};
                rd_lo_r <= !rd_lo_r;
                state_r <= ST_RD;
              end
            end
          end
          ST_RD: begin
            if (scl_rise) cnt_r <= cnt_r + 4'h1;
            if (scl_fall) begin
              if (cnt_r == 4'h8) begin
                O_SDA_OE <= 1'b0;
                state_r <= ST_MACK;
              end else begin
                O_SDA_OE <= !tx_r[7];
                tx_r <= {tx_r[6:0], 1'b1};
              end
            end
          end
        endcase
      end
    end
  end

  // Control registers; the identity index has no write path
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      high_r <= RST_HIGH;
      low_r <= RST_LOW;
      offset_r <= RST_OFFSET;
      unlock_r <= 1'b0;
    end else if (gc_hit_r) begin
      high_r <= RST_HIGH;
      low_r <= RST_LOW;
      offset_r <= RST_OFFSET;
      unlock_r <= 1'b0;
    end else if (wr_stb_r) begin
      if (ptr_r == IDX_HIGH) high_r <= wdata_r;
      if (ptr_r == IDX_LOW) low_r <= wdata_r;
      if (ptr_r == IDX_OFFSET) offset_r <= wdata_r;
      if (ptr_r == IDX_UNLOCK) unlock_r <= wdata_r[UNLOCK_BIT];
    end
  end

  // Scratch words reload from the store after any reset
  for (genvar k = 0; k < SCR_NUM; k++) begin : g_scr
    assign scr_hit[k] = (ptr_r == SCR_IDX[k]);
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
        scr_r[k] <= 16'h0000;
      end else if (boot_r) begin
        scr_r[k] <= I_NVM_STORED[16*k +: 16];
      end else if (wr_stb_r && scr_hit[k]) begin
        scr_r[k] <= wdata_r;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      boot_r <= 1'b1;
      O_NVM_WR <= 1'b0;
      O_NVM_SEL <= 2'h0;
      O_NVM_DATA <= 16'h0000;
    end else begin
      boot_r <= gc_hit_r;
      O_NVM_WR <= wr_stb_r && unlock_r && (|scr_hit);
      O_NVM_SEL <= scr_hit[2] ? 2'h2 : (scr_hit[1] ? 2'h1 : 2'h0);
      O_NVM_DATA <= wdata_r;
    end
  end

  // Reset wait before sampling starts
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wait_r <= WAIT_W'(GC_RESET_CYCLES_P);
      O_SAMPLING <= 1'b0;
    end else if (gc_hit_r) begin
      wait_r <= WAIT_W'(GC_RESET_CYCLES_P);
      O_SAMPLING <= 1'b0;
    end else if (wait_r != '0) begin
      wait_r <= wait_r - WAIT_W'(1);
    end else begin
      O_SAMPLING <= 1'b1;
    end
  end

  result_path u_result (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_run(O_SAMPLING),
    .i_avg_sel(I_AVG_SEL),
    .i_offset(offset_r),
    .i_valid(I_SAMPLE_VALID),
    .i_sample(I_SAMPLE),
    .o_result(result),
    .o_valid(res_valid)
  );

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_ALERT <= 1'b0;
    end else if (gc_hit_r) begin
      O_ALERT <= 1'b0;
    end else if (res_valid) begin
      O_ALERT <= ($signed(result) > $signed(high_r)) ||
                 ($signed(result) < $signed(low_r));
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_off_rst;
    gc_hit_r |=> offset_r == RST_OFFSET;
  endproperty
  a_off_rst: assert property (p_off_rst) else $error("offset not cleared");
  property p_scr_wr;
    wr_stb_r && scr_hit[1] && !boot_r |=> scr_r[1] == $past(wdata_r);
  endproperty
  a_scr_wr: assert property (p_scr_wr) else $error("scratch write lost");
  property p_scr_load;
    boot_r |=> scr_r[2] == $past(I_NVM_STORED[47:32]);
  endproperty
  a_scr_load: assert property (p_scr_load) else $error("scratch not reloaded");
  property p_nvm_wr;
    O_NVM_WR |-> $past(unlock_r) && $past(wr_stb_r);
  endproperty
  a_nvm_wr: assert property (p_nvm_wr) else $error("program while locked");
  // A write aimed at the identity index must leave every control register and the store alone
  property p_id_fixed;
    wr_stb_r && ptr_r == IDX_ID |=> !O_NVM_WR && $stable(offset_r) && $stable(high_r) &&
      $stable(low_r) && $stable(unlock_r);
  endproperty
  a_id_fixed: assert property (p_id_fixed) else $error("identity write not discarded");
  property p_id_ack;
    state_r == ST_WR && !gc_r && scl_fall && cnt_r == 4'h8 && !stop && !start
      |=> O_SDA_OE && state_r == ST_ACK;
  endproperty
  a_id_ack: assert property (p_id_ack) else $error("data byte not acked");
  property p_oe_slave;
    O_SDA_OE |-> state_r inside {ST_ACK, ST_RD};
  endproperty
  a_oe_slave: assert property (p_oe_slave) else $error("data driven out of turn");
  property p_gc_wait;
    gc_hit_r |=> !O_SAMPLING [*8];
  endproperty
  a_gc_wait: assert property (p_gc_wait) else $error("sampling before wait");
  property p_alert;
    res_valid && !gc_hit_r && $signed(result) > $signed(high_r) |=> O_ALERT;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missed");
  c_read: cover property (state_r == ST_RD && scl_fall);
  c_gc: cover property (gc_hit_r);
  c_nvm: cover property (O_NVM_WR);
  c_alert: cover property ($rose(O_ALERT));
endmodule
`default_nettype wire

//--- shared/tsense_pkg.sv
// Purpose: Shared constants for the offset, scratch and identity register bank
// Assumes: 100 MHz core clock
// Notes: Register indices are the byte values carried in the bus pointer
`default_nettype none
package tsense_pkg;
  // Register indices
  localparam logic [7:0] IDX_RESULT = 8'h00;
  localparam logic [7:0] IDX_HIGH = 8'h02;
  localparam logic [7:0] IDX_LOW = 8'h03;
  localparam logic [7:0] IDX_UNLOCK = 8'h04;
  localparam logic [7:0] IDX_SCR_A = 8'h05;
  localparam logic [7:0] IDX_SCR_B = 8'h06;
  localparam logic [7:0] IDX_OFFSET = 8'h07;
  localparam logic [7:0] IDX_SCR_C = 8'h08;
  localparam logic [7:0] IDX_ID = 8'h0F;
  localparam int SCR_NUM = 3;
  localparam logic [7:0] SCR_IDX [SCR_NUM] = '{IDX_SCR_A, IDX_SCR_B, IDX_SCR_C};
  // Reset values
  localparam logic [15:0] RST_HIGH = 16'h6000;
  localparam logic [15:0] RST_LOW = 16'h8000;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  // Field positions
  localparam int UNLOCK_BIT = 15;
  // Temperature code: 7.8125 m-degrees per LSB, span +-256 degrees
  localparam real LSB_MILLIDEG = 7.8125;
  localparam int SPAN_DEG = 256;
  localparam logic [15:0] TEMP_MAX = 16'h7FFF;
  localparam logic [15:0] TEMP_MIN = 16'h8000;
  // Averaging shift per select code: 1, 8, 32, 64 samples
  localparam logic [2:0] AVG_SHIFT [4] = '{3'h0, 3'h3, 3'h5, 3'h6};
  // Two-wire bus
  localparam logic [4:0] BUS_ADDR_BASE = 5'h12;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_VCC = 2'h1;
  localparam logic [1:0] SEL_SDA = 2'h2;
  localparam logic [1:0] SEL_SCL = 2'h3;
  // Timing
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real GC_RESET_MS = 1.5;
  localparam int GC_RESET_CYCLES = int'(GC_RESET_MS * 1.0e6 / CLK_PERIOD_NS);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_MACK} bus_state_type;
endpackage
`default_nettype wire

//--- core/result_path.sv
// Purpose: Averages conversions and adds the saturating user offset
// Assumes: Samples arrive on the core clock as signed 16-bit codes
// Notes: Accumulator restarts whenever sampling is stopped
`timescale 1ns/1ns
`default_nettype none
module result_path import tsense_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  input wire logic [1:0] i_avg_sel,
  input wire logic [15:0] i_offset,
  // Samples
  input wire logic i_valid,
  input wire logic [15:0] i_sample,
  // Result
  output logic [15:0] o_result,
  output logic o_valid
);
  logic signed [21:0] acc_r;
  logic [6:0] cnt_r;
  logic [2:0] sh;
  logic [6:0] need;
  logic signed [21:0] acc_nxt;
  logic signed [15:0] avg;
  logic signed [16:0] sum;
  logic last;

  always_comb begin
    sh = AVG_SHIFT[i_avg_sel];
    need = 7'h1 << sh;
    acc_nxt = acc_r + 22'(signed'(i_sample));
    avg = 16'(acc_nxt >>> sh);
    sum = 17'(avg) + 17'(signed'(i_offset));
    last = i_run && i_valid && (cnt_r + 7'h1 == need);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_r <= '0;
      cnt_r <= 7'h0;
      o_result <= 16'h0000;
      o_valid <= 1'b0;
    end else begin
      o_valid <= last;
      if (!i_run || last) begin
        acc_r <= '0;
        cnt_r <= 7'h0;
      end else if (i_valid) begin
        acc_r <= acc_nxt;
        cnt_r <= cnt_r + 7'h1;
      end
      if (last) begin
        if (sum[16] != sum[15]) begin
          o_result <= sum[16] ? TEMP_MIN : TEMP_MAX;
        end else begin
          o_result <= sum[15:0];
        end
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_sat_hi;
    last && !sum[16] && sum[15] |=> o_result == TEMP_MAX;
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("positive overflow not clamped");
  property p_sat_lo;
    last && sum[16] && !sum[15] |=> o_result == TEMP_MIN;
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("negative overflow not clamped");
  property p_offset_add;
    last && (sum[16] == sum[15]) |=> o_result == $past(sum[15:0]);
  endproperty
  a_offset_add: assert property (p_offset_add) else $error("offset not added");
  property p_avg_count;
    o_valid |-> $past(cnt_r) + 7'h1 == $past(need);
  endproperty
  a_avg_count: assert property (p_avg_count) else $error("wrong sample count");
  c_avg64: cover property (last && i_avg_sel == 2'h3);
endmodule
`default_nettype wire

//--- core/offset_scratch_id_regs_end.sv
// Purpose: Closes the net type setting for the register bank sources
// Assumes: Read after the other core files
// Notes: Holds no logic
`default_nettype none
`default_nettype wire

//--- verification/bus_host_model.sv
// Purpose: Two-wire bus host that drives clock and data as open-drain pulls
// Assumes: Both lines pulled up outside; ten core clocks per phase
// Notes: Pins change only at falling core clock edges
`timescale 1ns/1ns
`default_nettype none
module bus_host_model (
  // Clock
  input wire logic i_clk,
  // Bus lines
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  task automatic ph();
    repeat (10) @(negedge i_clk);
  endtask
  // Start or repeated start, data falls while clock is high
  task automatic start();
    ph();
    o_sda_low = 1'b0;
    ph();
    o_scl_low = 1'b0;
    ph();
    o_sda_low = 1'b1;
    ph();
    o_scl_low = 1'b1;
  endtask
  task automatic stop();
    ph();
    o_sda_low = 1'b1;
    ph();
    o_scl_low = 1'b0;
    ph();
    o_sda_low = 1'b0;
    ph();
  endtask
  // Data moves only in the clock low phase, sampled at end of high phase
  task automatic bit_x(input logic b, output logic r);
    ph();
    o_sda_low = !b;
    ph();
    o_scl_low = 1'b0;
    ph();
    r = i_sda;
    o_scl_low = 1'b1;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, r);
  endtask
endmodule
`default_nettype wire

//--- verification/offset_scratch_id_regs_test.sv
// Purpose: Self-checking bench for the offset, scratch and identity bank
// Assumes: Host model on the bus; reset wait shortened to 200 cycles
// Notes: Scratch word at 05h is never written by the host
`timescale 1ns/1ns
`default_nettype none
module offset_scratch_id_regs_test import tsense_pkg::*;;
  localparam logic [47:0] STORED = 48'hC0DE_BEEF_1357;
  localparam logic [3:0] REV = 4'h6; // Arbitrary value
  localparam logic [11:0] PART = 12'h3C9; // Arbitrary value
  logic clk, rst, scl_low, sda_low, sda_o, sda_oe, sda_w, scl_w, sel_pin;
  logic svalid, sampling, alert, nvm_wr;
  logic [1:0] sel_mode, avg, nvm_sel;
  logic [15:0] sample, nvm_data, v;
  logic [17:0] nvm_last = 18'h00000;
  int fails, comparisons;
  int nvm_cnt = 0;
  assign sda_w = !(sda_low | (sda_oe & !sda_o));
  assign scl_w = !scl_low;
  assign sel_pin = (sel_mode == SEL_GND) ? 1'b0 : (sel_mode == SEL_VCC) ? 1'b1 :
                   (sel_mode == SEL_SDA) ? sda_w : scl_w;
  offset_scratch_id_regs #(.GC_RESET_CYCLES_P(200), .REV_FIELD(REV),
    .PART_CODE_FIELD(PART)) u_offset_scratch_id_regs (.I_CORE_CLK(clk),
    .I_SYS_RST(rst), .I_SCL(scl_w), .I_SDA(sda_w), .O_SDA_O(sda_o),
    .O_SDA_OE(sda_oe), .I_ADDRESS_SELECT_PIN(sel_pin), .I_SAMPLE(sample),
    .I_SAMPLE_VALID(svalid), .I_AVG_SEL(avg), .O_SAMPLING(sampling),
    .O_ALERT(alert), .I_NVM_STORED(STORED), .O_NVM_WR(nvm_wr),
    .O_NVM_SEL(nvm_sel), .O_NVM_DATA(nvm_data));
  bus_host_model u_bus_host_model (.i_clk(clk), .i_sda(sda_w), .o_scl_low(scl_low),
    .o_sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (nvm_wr === 1'b1) begin
      nvm_cnt <= nvm_cnt + 1;
      nvm_last <= {nvm_sel, nvm_data};
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic ack_exp);
    logic a;
    u_bus_host_model.wr_byte(d, a);
    check({15'h0000, a}, {15'h0000, ack_exp});
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d);
    u_bus_host_model.start();
    wb({BUS_ADDR_BASE, sel_mode, 1'b0}, 1'b1);
    wb(idx, 1'b1);
    wb(d[15:8], 1'b1);
    wb(d[7:0], 1'b1);
    u_bus_host_model.stop();
  endtask
  task automatic expect_reg(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    u_bus_host_model.start();
    wb({BUS_ADDR_BASE, sel_mode, 1'b0}, 1'b1);
    wb(idx, 1'b1);
    u_bus_host_model.start();
    wb({BUS_ADDR_BASE, sel_mode, 1'b1}, 1'b1);
    u_bus_host_model.rd_byte(1'b0, d[15:8]);
    u_bus_host_model.rd_byte(1'b1, d[7:0]);
    u_bus_host_model.stop();
    check(d, exp);
  endtask
  task automatic feed(input logic [15:0] s);
    @(negedge clk);
    sample = s;
    svalid = 1'b1;
    @(negedge clk);
    svalid = 1'b0;
  endtask
  task automatic wait_sampling();
    for (int n = 0; n < 300 && sampling !== 1'b1; n++) begin
      @(negedge clk);
    end
  endtask
  task automatic t_reset();
    check({15'h0000, sampling}, 16'h0001);
    expect_reg(IDX_OFFSET, 16'h0000);
    expect_reg(IDX_SCR_A, STORED[15:0]);
    expect_reg(IDX_SCR_B, STORED[31:16]);
    expect_reg(IDX_SCR_C, STORED[47:32]);
    expect_reg(IDX_ID, {REV, PART});
    expect_reg(8'h0A, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_rw();
    wr_reg(IDX_SCR_B, 16'hA55A);
    wr_reg(IDX_OFFSET, 16'h1234);
    wr_reg(IDX_SCR_C, 16'h5AA5);
    wr_reg(IDX_ID, 16'h0000);
    expect_reg(IDX_SCR_B, 16'hA55A);
    expect_reg(IDX_OFFSET, 16'h1234);
    expect_reg(IDX_SCR_C, 16'h5AA5);
    expect_reg(IDX_ID, {REV, PART});
    check(nvm_cnt[15:0], 16'h0000);
    $display("test read write done");
  endtask
  task automatic t_addr();
    for (int s = 0; s < 4; s++) begin
      sel_mode = s[1:0];
      wr_reg(IDX_SCR_B, {4{s[3:0]}});
      expect_reg(IDX_SCR_B, {4{s[3:0]}});
      u_bus_host_model.start();
      wb({BUS_ADDR_BASE, ~sel_mode, 1'b0}, 1'b0);
      u_bus_host_model.stop();
    end
    sel_mode = SEL_GND;
    $display("test address done");
  endtask
  task automatic t_nvm();
    wr_reg(IDX_UNLOCK, 16'h8000);
    wr_reg(IDX_SCR_C, 16'hC3C3);
    check(nvm_cnt[15:0], 16'h0001);
    check({14'h0000, nvm_last[17:16]}, 16'h0002);
    check(nvm_last[15:0], 16'hC3C3);
    expect_reg(IDX_SCR_C, 16'hC3C3);
    wr_reg(IDX_UNLOCK, 16'h0000);
    $display("test storage done");
  endtask
  task automatic t_offset();
    wr_reg(IDX_OFFSET, 16'h0003);
    feed(16'h0010);
    expect_reg(IDX_RESULT, 16'h0013);
    wr_reg(IDX_OFFSET, 16'hFFFE);
    feed(16'h0010);
    expect_reg(IDX_RESULT, 16'h000E);
    wr_reg(IDX_OFFSET, 16'h7FF0);
    feed(16'h0100);
    expect_reg(IDX_RESULT, TEMP_MAX);
    check({15'h0000, alert}, 16'h0001);
    wr_reg(IDX_OFFSET, 16'h8000);
    feed(16'hFF00);
    expect_reg(IDX_RESULT, TEMP_MIN);
    check({15'h0000, alert}, 16'h0000);
    $display("test offset done");
  endtask
  task automatic t_avg();
    wr_reg(IDX_OFFSET, 16'h0000);
    avg = 2'h1;
    for (int i = 0; i < 8; i++) begin
      feed(i < 4 ? 16'h0010 : 16'h0030);
    end
    expect_reg(IDX_RESULT, 16'h0020);
    avg = 2'h2;
    for (int i = 0; i < 32; i++) begin
      feed(i[0] ? 16'h0080 : 16'h0000);
    end
    expect_reg(IDX_RESULT, 16'h0040);
    avg = 2'h3;
    for (int i = 0; i < 64; i++) begin
      feed(16'hFFF0);
    end
    expect_reg(IDX_RESULT, 16'hFFF0);
    avg = 2'h0;
    $display("test average done");
  endtask
  task automatic t_gcall();
    wr_reg(IDX_SCR_B, 16'h1111);
    wr_reg(IDX_OFFSET, 16'h0042);
    u_bus_host_model.start();
    wb(8'h00, 1'b1);
    wb(GC_RESET_CMD, 1'b1);
    u_bus_host_model.stop();
    check({15'h0000, sampling}, 16'h0000);
    wait_sampling();
    check({15'h0000, sampling}, 16'h0001);
    expect_reg(IDX_OFFSET, 16'h0000);
    expect_reg(IDX_SCR_B, STORED[31:16]);
    $display("test general call done");
  endtask
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    sel_mode = SEL_GND;
    avg = 2'h0;
    sample = 16'h0000;
    svalid = 1'b0;
    fails = 0;
    comparisons = 0;
    // Count rising edges so the start value of the clock cannot shorten reset
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    wait_sampling();
    t_reset();
    t_rw();
    t_addr();
    t_nvm();
    t_offset();
    t_avg();
    t_gcall();
    test_done();
  end
  initial begin
    #900000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
